// ---- hdl/dsm_defs.svh ----
// Offsets, field positions, reset values and limits of the mixer block
`ifndef DSM_DEFS_SVH
`define DSM_DEFS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define DSM_A_TRIG   8'h00
`define DSM_A_RATE   8'h04
`define DSM_A_OCTL   8'h08
`define DSM_A_AEN    8'h0C
`define DSM_A_OFS1   8'h10
`define DSM_A_OFS2   8'h14
`define DSM_A_STAT   8'h60
`define DSM_AMP1_HI  3'h1
`define DSM_AMP2_HI  3'h2
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DSM_F_STREAM 7
`define DSM_F_ON     0
`define DSM_F_HIRNG  1
`define DSM_F_AUTO   2
`define DSM_F_LOAD50 3
`define DSM_F_DIFF   4
`define DSM_F_WGEN   5
`define DSM_OSTRIDE  8
// ----------------------------------------
// Reset values and limits (0.1 mV units)
// ----------------------------------------
`define DSM_RST_TRIG 8'h00
`define DSM_RST_RATE 16'h03E7
`define DSM_RST_OCTL 16'h0000
`define DSM_RST_AEN  16'h8008
`define DSM_LIM_LOW  24'h0005DC
`define DSM_LIM_HIGH 24'h003A98
`define DSM_OKAY     2'h0
`define DSM_SLVERR   2'h2
`endif

// ---- hdl/dsm_pkg.sv ----
// Types shared by the mixer block
`default_nettype none
package dsm_pkg;
   typedef enum logic [3:0] {
      DSM_SRC_CONT, DSM_SRC_EXT3, DSM_SRC_EXT4, DSM_SRC_EXT34,
      DSM_SRC_WG1, DSM_SRC_WG2, DSM_SRC_WG3, DSM_SRC_WG4
   } dsm_src_e;
   typedef enum logic [2:0] {
      DSM_M_RISE, DSM_M_FALL, DSM_M_BOTH, DSM_M_HIGH, DSM_M_LOW
   } dsm_mode_e;
endpackage : dsm_pkg
`default_nettype wire

// ---- hdl/dsm_top.sv ----
// Sample trigger gate and two-output amplitude mixer with AXI4-Lite regs
// Operation
// R01: Wavegen trigger four gates sample sending
// R02: Rising edge sends one sample
// R03: Falling edge sends one sample
// R04: Either edge sends one sample
// R05: High level streams at rate
// R06: Low level streams at rate
// R07: Edge modes ignore the rate
// R08: Range limits the whole sum
// R09: Saturate at limit, flag clipping
// R10: Two ranges, low and high
// R11: Load or differential halves the limit
// R12: Clamped offset added to sum
// R13: Negative amplitude inverts the sine
// R14: Demods four and eight feed outputs
// R15: Each contribution has own enable
// R16: Output is weighted sum of sines
// R17: Main switch gates output and LED
// R18: Report sine or wavegen source
// R19: Auto range picks smallest fitting range
// R20: Continuous mode streams at rate
// R21: Synchronise trigger, one sample per edge
`include "dsm_defs.svh"
`default_nettype none
module dsm_top (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        trig_in3,
   input  wire logic        trig_in4,
   input  wire logic [3:0]  wavegen_trig,
   input  wire logic        wavegen_present,
   input  wire logic [31:0] demod_sample,
   input  wire logic [127:0] osc_sine,
   output var  logic        smp_valid,
   output var  logic [31:0] smp_data,
   output var  logic [15:0] out1_code,
   output var  logic [15:0] out2_code,
   output var  logic [1:0]  led_on,
   output var  logic [1:0]  clip
);
   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic [1:0] rst_sync;
   logic       rst_n_q;
   // Two-stage release keeps deassertion clean
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) rst_sync <= 2'h0;
      else       rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n_q = rst_sync[1];

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   logic [7:0]  trig_ctrl, next_trig_ctrl;
   logic [15:0] rate_div, next_rate_div;
   logic [15:0] out_ctrl, next_out_ctrl;
   logic [15:0] amp_en, next_amp_en;
   logic [15:0] offs [2];
   logic [15:0] next_offs [2];
   logic [15:0] amp [16];
   logic [15:0] next_amp [16];
   logic [1:0]  clip_sticky, next_clip_sticky;
   logic [7:0]  aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0]  w_strb, next_w_strb;
   logic        next_awready, next_wready, next_bvalid;
   logic [1:0]  next_bresp, next_rresp;
   logic        next_arready, next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  clip_now, range_eff;
   logic [1:0]  wave_mode;

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // Next register state from the bus
   always_comb begin
      next_trig_ctrl   = trig_ctrl;
      next_rate_div    = rate_div;
      next_out_ctrl    = out_ctrl;
      next_amp_en      = amp_en;
      next_offs        = offs;
      next_amp         = amp;
      next_clip_sticky = clip_sticky;
      next_aw_addr     = aw_addr;
      next_w_data      = w_data;
      next_w_strb      = w_strb;
      next_awready     = s_axi_awready;
      next_wready      = s_axi_wready;
      next_bvalid      = s_axi_bvalid;
      next_bresp       = s_axi_bresp;
      next_arready     = s_axi_arready;
      next_rvalid      = s_axi_rvalid;
      next_rdata       = s_axi_rdata;
      next_rresp       = s_axi_rresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_addr = s_axi_awaddr;
         next_awready = 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
         next_wready = 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) next_bvalid = 1'b0;
      // Write once both halves are held
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
         next_bvalid  = 1'b1;
         next_awready = 1'b1;
         next_wready  = 1'b1;
         next_bresp   = `DSM_OKAY;
         unique case (aw_addr)
            `DSM_A_TRIG: begin
               if (w_strb[0]) next_trig_ctrl = w_data[7:0];
            end
            `DSM_A_RATE: next_rate_div = merge(rate_div, w_data, w_strb);
            `DSM_A_OCTL: next_out_ctrl = merge(out_ctrl, w_data, w_strb);
            `DSM_A_AEN:  next_amp_en = merge(amp_en, w_data, w_strb);
            `DSM_A_OFS1: next_offs[0] = merge(offs[0], w_data, w_strb);
            `DSM_A_OFS2: next_offs[1] = merge(offs[1], w_data, w_strb);
            `DSM_A_STAT: begin
               if (w_strb[0]) next_clip_sticky = clip_sticky & ~w_data[3:2];
            end
            default: begin
               if (aw_addr[7:5] == `DSM_AMP1_HI)
                  next_amp[{1'b0, aw_addr[4:2]}] =
                     merge(amp[{1'b0, aw_addr[4:2]}], w_data, w_strb);
               else if (aw_addr[7:5] == `DSM_AMP2_HI)
                  next_amp[{1'b1, aw_addr[4:2]}] =
                     merge(amp[{1'b1, aw_addr[4:2]}], w_data, w_strb);
               else
                  next_bresp = `DSM_SLVERR;
            end
         endcase
      end
      // R09 sticky clip, set wins
      next_clip_sticky = next_clip_sticky | clip_now;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid  = 1'b0;
         next_arready = 1'b1;
      end
      // Read answer one cycle after address
      if (s_axi_arvalid && s_axi_arready) begin
         next_arready = 1'b0;
         next_rvalid  = 1'b1;
         next_rresp   = `DSM_OKAY;
         next_rdata   = 32'h00000000;
         unique case (s_axi_araddr)
            `DSM_A_TRIG: next_rdata = {24'h000000, trig_ctrl};
            `DSM_A_RATE: next_rdata = {16'h0000, rate_div};
            `DSM_A_OCTL: next_rdata = {16'h0000, out_ctrl};
            `DSM_A_AEN:  next_rdata = {16'h0000, amp_en};
            `DSM_A_OFS1: next_rdata = {16'h0000, offs[0]};
            `DSM_A_OFS2: next_rdata = {16'h0000, offs[1]};
            // R18 source status readback
            `DSM_A_STAT: next_rdata = {24'h000000, wave_mode, range_eff,
                                       clip_sticky, clip};
            default: begin
               if (s_axi_araddr[7:5] == `DSM_AMP1_HI)
                  next_rdata = {16'h0000, amp[{1'b0, s_axi_araddr[4:2]}]};
               else if (s_axi_araddr[7:5] == `DSM_AMP2_HI)
                  next_rdata = {16'h0000, amp[{1'b1, s_axi_araddr[4:2]}]};
               else
                  next_rresp = `DSM_SLVERR;
            end
         endcase
      end
   end

   // Bus and configuration registers
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         trig_ctrl     <= `DSM_RST_TRIG;
         rate_div      <= `DSM_RST_RATE;
         out_ctrl      <= `DSM_RST_OCTL;
         // R14 demods four and eight by default
         amp_en        <= `DSM_RST_AEN;
         for (int i = 0; i < 2; i++) offs[i] <= 16'h0000;
         for (int i = 0; i < 16; i++) amp[i] <= 16'h0000;
         clip_sticky   <= 2'h0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'h0;
      end else begin
         trig_ctrl     <= next_trig_ctrl;
         rate_div      <= next_rate_div;
         out_ctrl      <= next_out_ctrl;
         amp_en        <= next_amp_en;
         offs          <= next_offs;
         amp           <= next_amp;
         clip_sticky   <= next_clip_sticky;
         aw_addr       <= next_aw_addr;
         w_data        <= next_w_data;
         w_strb        <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
   end

   // ----------------------------------------
   // Trigger gate
   // ----------------------------------------
   dsm_pkg::dsm_src_e  src;
   dsm_pkg::dsm_mode_e mode;
   logic [2:0]  s3, s4, next_s3, next_s4;
   logic        f3, f4, next_f3, next_f4;
   logic        sel_lvl, sel_q, fire, tick, edge_mode;
   logic [15:0] rate_cnt, next_rate_cnt;
   logic        next_smp_valid;
   logic [31:0] next_smp_data;

   assign src  = dsm_pkg::dsm_src_e'(trig_ctrl[3:0]);
   assign mode = dsm_pkg::dsm_mode_e'(trig_ctrl[6:4]);
   assign tick = (rate_cnt == 16'h0000);
   assign edge_mode = (mode == dsm_pkg::DSM_M_RISE) ||
                      (mode == dsm_pkg::DSM_M_FALL) ||
                      (mode == dsm_pkg::DSM_M_BOTH);

   // Pin sync, filter and sample gating
   always_comb begin
      // R21 three stages, last two must agree
      next_s3 = {s3[1:0], trig_in3};
      next_s4 = {s4[1:0], trig_in4};
      next_f3 = (s3[2] == s3[1]) ? s3[2] : f3;
      next_f4 = (s4[2] == s4[1]) ? s4[2] : f4;
      // Clamp to a lowered rate so it acts at once, not after old count
      next_rate_cnt = (tick || rate_cnt > rate_div) ? rate_div
                                                    : rate_cnt - 16'h0001;
      unique case (src)
         dsm_pkg::DSM_SRC_EXT3:  sel_lvl = f3;
         dsm_pkg::DSM_SRC_EXT4:  sel_lvl = f4;
         dsm_pkg::DSM_SRC_EXT34: sel_lvl = f3 | f4;
         dsm_pkg::DSM_SRC_WG1:   sel_lvl = wavegen_trig[0];
         dsm_pkg::DSM_SRC_WG2:   sel_lvl = wavegen_trig[1];
         dsm_pkg::DSM_SRC_WG3:   sel_lvl = wavegen_trig[2];
         // R01 wavegen_trigger_four source
         dsm_pkg::DSM_SRC_WG4:   sel_lvl = wavegen_trig[3];
         default:                sel_lvl = 1'b0;
      endcase
      if (src == dsm_pkg::DSM_SRC_CONT) begin
         // R20 continuous at rate
         fire = tick;
      end else begin
         unique case (mode)
            // R02 rising edge
            dsm_pkg::DSM_M_RISE: fire = sel_lvl & ~sel_q;
            // R03 falling edge
            dsm_pkg::DSM_M_FALL: fire = ~sel_lvl & sel_q;
            // R04 R07 edges only, rate unused
            dsm_pkg::DSM_M_BOTH: fire = sel_lvl ^ sel_q;
            // R05 high level at rate
            dsm_pkg::DSM_M_HIGH: fire = tick & sel_lvl;
            // R06 low level at rate
            dsm_pkg::DSM_M_LOW:  fire = tick & ~sel_lvl;
            default:             fire = 1'b0;
         endcase
      end
      fire = fire & trig_ctrl[`DSM_F_STREAM];
      next_smp_valid = fire;
      next_smp_data  = fire ? demod_sample : smp_data;
   end

   // Trigger registers
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         s3 <= 3'h0;
         s4 <= 3'h0;
         f3 <= 1'b0;
         f4 <= 1'b0;
         sel_q     <= 1'b0;
         rate_cnt  <= 16'h0000;
         smp_valid <= 1'b0;
         smp_data  <= 32'h00000000;
      end else begin
         s3 <= next_s3;
         s4 <= next_s4;
         f3 <= next_f3;
         f4 <= next_f4;
         // R21 previous level for edge compare
         sel_q     <= sel_lvl;
         rate_cnt  <= next_rate_cnt;
         smp_valid <= next_smp_valid;
         smp_data  <= next_smp_data;
      end
   end

   // ----------------------------------------
   // Output mixer
   // ----------------------------------------
   logic [15:0] next_out [2];
   logic [1:0]  next_led;

   // Weighted sine sum, offset, range and clip
   always_comb begin : mix
      logic signed [31:0] prod;
      logic signed [23:0] sum, off, lim, tot;
      logic        [23:0] peak;
      logic        [16:0] mag;
      logic               hi, half;
      prod = 32'sh00000000;
      sum = 24'sh000000;
      off = 24'sh000000;
      lim = 24'sh000000;
      tot = 24'sh000000;
      peak = 24'h000000;
      mag = 17'h00000;
      hi = 1'b0;
      half = 1'b0;
      next_led  = 2'h0;
      clip_now  = 2'h0;
      range_eff = 2'h0;
      wave_mode = 2'h0;
      for (int o = 0; o < 2; o++) begin
         sum  = 24'sh000000;
         peak = 24'h000000;
         for (int d = 0; d < 8; d++) begin
            // R15 R16 enabled terms only
            if (amp_en[o*8+d]) begin
               // R13 signed product flips phase
               prod = $signed(osc_sine[d*16 +: 16]) * $signed(amp[o*8+d]);
               sum  = sum + {{7{prod[31]}}, prod[31:15]};
               mag  = amp[o*8+d][15] ? 17'h00000 - {1'b1, amp[o*8+d]}
                                     : {1'b0, amp[o*8+d]};
               peak = peak + {7'h00, mag};
            end
         end
         off = {{8{offs[o][15]}}, offs[o]};
         mag = off[23] ? 17'h00000 - off[16:0] : off[16:0];
         peak = peak + {7'h00, mag};
         // R11 load or differential halves
         half = out_ctrl[o*8+`DSM_F_LOAD50] | out_ctrl[o*8+`DSM_F_DIFF];
         lim  = half ? (`DSM_LIM_LOW >> 1) : `DSM_LIM_LOW;
         // R19 auto picks low when it fits
         if (out_ctrl[o*8+`DSM_F_AUTO]) hi = (peak > lim);
         else                           hi = out_ctrl[o*8+`DSM_F_HIRNG];
         // R10 two symmetric ranges
         if (hi) lim = half ? (`DSM_LIM_HIGH >> 1) : `DSM_LIM_HIGH;
         range_eff[o] = hi;
         // R12 offset held inside range
         if (off > lim)       off = lim;
         else if (off < -lim) off = -lim;
         // R08 limit applies to the total
         tot = sum + off;
         // R09 saturate and flag
         if (tot > lim) begin
            tot = lim;
            clip_now[o] = 1'b1;
         end else if (tot < -lim) begin
            tot = -lim;
            clip_now[o] = 1'b1;
         end
         // R17 main switch gates output
         next_led[o] = out_ctrl[o*8+`DSM_F_ON];
         next_out[o] = next_led[o] ? tot[15:0] : 16'h0000;
         // R18 wavegen only when fitted and enabled
         wave_mode[o] = wavegen_present & out_ctrl[o*8+`DSM_F_WGEN];
      end
   end

   // Output registers
   always_ff @(posedge clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
         out1_code <= 16'h0000;
         out2_code <= 16'h0000;
         led_on    <= 2'h0;
         clip      <= 2'h0;
      end else begin
         out1_code <= next_out[0];
         out2_code <= next_out[1];
         led_on    <= next_led;
         clip      <= clip_now;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_wg4;
      @(posedge clk_sys) disable iff (!rst_n_q)
      (trig_ctrl[`DSM_F_STREAM] && src == dsm_pkg::DSM_SRC_WG4 &&
       mode == dsm_pkg::DSM_M_RISE && wavegen_trig[3] && !sel_q)
      |=> smp_valid;
   endproperty
   a_wg4: assert property (p_wg4) else $error("wg4 edge lost"); // R01
   property p_rise;
      @(posedge clk_sys) disable iff (!rst_n_q)
      (trig_ctrl[`DSM_F_STREAM] && src != dsm_pkg::DSM_SRC_CONT &&
       mode == dsm_pkg::DSM_M_RISE && sel_lvl && !sel_q) |=> smp_valid;
   endproperty
   a_rise: assert property (p_rise) else $error("rise lost"); // R02
   property p_fall;
      @(posedge clk_sys) disable iff (!rst_n_q)
      (trig_ctrl[`DSM_F_STREAM] && src != dsm_pkg::DSM_SRC_CONT &&
       mode == dsm_pkg::DSM_M_FALL && !sel_lvl && sel_q) |=> smp_valid;
   endproperty
   a_fall: assert property (p_fall) else $error("fall lost"); // R03
   property p_edge_quiet;
      @(posedge clk_sys) disable iff (!rst_n_q)
      (src != dsm_pkg::DSM_SRC_CONT && edge_mode && sel_lvl == sel_q)
      |=> !smp_valid;
   endproperty
   a_edge_quiet: assert property (p_edge_quiet) // R07
      else $error("sample without edge");
   property p_high;
      @(posedge clk_sys) disable iff (!rst_n_q)
      (src != dsm_pkg::DSM_SRC_CONT && mode == dsm_pkg::DSM_M_HIGH &&
       !sel_lvl) |=> !smp_valid;
   endproperty
   a_high: assert property (p_high) else $error("sample while low"); // R05
   property p_low;
      @(posedge clk_sys) disable iff (!rst_n_q)
      (src != dsm_pkg::DSM_SRC_CONT && mode == dsm_pkg::DSM_M_LOW &&
       sel_lvl) |=> !smp_valid;
   endproperty
   a_low: assert property (p_low) else $error("sample while high"); // R06
   property p_cont;
      @(posedge clk_sys) disable iff (!rst_n_q)
      (trig_ctrl[`DSM_F_STREAM] && src == dsm_pkg::DSM_SRC_CONT && tick)
      |=> smp_valid ##1 !smp_valid || rate_div == 16'h0000;
   endproperty
   a_cont: assert property (p_cont) else $error("rate stream bad"); // R20
   property p_clip;
      @(posedge clk_sys) disable iff (!rst_n_q)
      clip_now[0] |=> clip[0] && clip_sticky[0];
   endproperty
   a_clip: assert property (p_clip) else $error("clip flag lost"); // R09
   property p_off;
      @(posedge clk_sys) disable iff (!rst_n_q)
      !out_ctrl[`DSM_F_ON] |=> out1_code == 16'h0000 && !led_on[0];
   endproperty
   a_off: assert property (p_off) else $error("output not gated"); // R17
   c_rise: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
      mode == dsm_pkg::DSM_M_RISE && smp_valid);
   c_clip: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
      $rose(clip[0]));
   c_cont: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
      src == dsm_pkg::DSM_SRC_CONT && smp_valid ##10 smp_valid);
endmodule // dsm_top
`default_nettype wire

// ---- tb/dsm_host_model.sv ----
// Host side model that receives the demodulated sample stream
`default_nettype none
module dsm_host_model (
   input  wire logic        clk_sys,
   input  wire logic        clr,
   input  wire logic        smp_valid,
   input  wire logic [31:0] smp_data,
   output var  logic [15:0] cnt,
   output var  logic [31:0] last
);
   timeunit 1ns;
   timeprecision 1ns;
   // Host never stalls, so every pulse is one sample
   always_ff @(posedge clk_sys) begin
      if (clr) cnt <= 16'h0000;
      else if (smp_valid) cnt <= cnt + 16'h0001;
      if (smp_valid) last <= smp_data;
   end
endmodule // dsm_host_model
`default_nettype wire

// ---- tb/dsm_top_test.sv ----
// Self-checking bench for the sample gate and output mixer
`include "dsm_defs.svh"
`default_nettype none
module dsm_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, rstn = 1'h0, clr = 1'h0, bready = 1'h0, rready = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, smp_valid;
   logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]  wdata = 32'h0, rdata, smp_data, last;
   logic [31:0]  dsamp = 32'hA5A50F0F;
   logic [1:0]   bresp, rresp, led_on, clip;
   logic [3:0]   wg = 4'h0;
   logic         wgp = 1'h0;
   logic [127:0] sine = {112'h0, 16'h7FFF};
   logic [15:0]  out1, out2, cnt;
   int           n_errors = 0, total_checks = 0;
   // Trigger pin three follows trigger four and pin four its inverse, so the pin sync path is exercised
   dsm_top uut (.clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .trig_in3(wg[3]), .trig_in4(~wg[3]),
      .wavegen_trig(wg), .wavegen_present(wgp), .demod_sample(dsamp),
      .osc_sine(sine), .smp_valid(smp_valid), .smp_data(smp_data),
      .out1_code(out1), .out2_code(out2), .led_on(led_on), .clip(clip));
   dsm_host_model host (.clk_sys(clk_sys), .clr(clr),
      .smp_valid(smp_valid), .smp_data(smp_data), .cnt(cnt), .last(last));
   // ----------------------------------------
   // Clock, shared tasks
   // ----------------------------------------
   initial begin
      clk_sys = 1'h0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Outputs are sampled at the falling edge to dodge update races
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] e;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(negedge clk_sys);
         aw = awready;
         w = wready;
         b = bvalid;
         e = bresp;
         @(posedge clk_sys);
         if (aw === 1'h1) awvalid <= 1'h0;
         if (w === 1'h1) wvalid <= 1'h0;
      end while (b !== 1'h1);
      bready <= 1'h0;
      @(posedge clk_sys);
      chk(e, er);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      logic ar, r;
      logic [31:0] d;
      logic [1:0] e;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(negedge clk_sys);
         ar = arready;
         r = rvalid;
         d = rdata;
         e = rresp;
         @(posedge clk_sys);
         if (ar === 1'h1) arvalid <= 1'h0;
      end while (r !== 1'h1);
      rready <= 1'h0;
      @(posedge clk_sys);
      chk(d, ed);
      chk(e, er);
   endtask
   // Fixed windows: active 50 cycles, count over exactly 100 edges
   task automatic trig(input logic [7:0] t, input logic i,
                       input logic [15:0] ex);
      wg[3] <= i;
      repeat (5) @(posedge clk_sys);
      wr(`DSM_A_TRIG, {24'h0, t}, `DSM_OKAY);
      clr <= 1'h1;
      wg[3] <= ~i;
      @(posedge clk_sys);
      clr <= 1'h0;
      repeat (49) @(posedge clk_sys);
      wg[3] <= i;
      repeat (51) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(cnt, ex);
      @(posedge clk_sys);
   endtask
   task automatic mchk(input logic [15:0] o, input logic c);
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(out1, o);
      chk(clip[0], c);
      chk(out2, 32'h0);
      @(posedge clk_sys);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      rd(`DSM_A_TRIG, 32'h0, `DSM_OKAY);
      rd(`DSM_A_RATE, {16'h0, `DSM_RST_RATE}, `DSM_OKAY);
      rd(`DSM_A_AEN, {16'h0, `DSM_RST_AEN}, `DSM_OKAY);
      rd(8'h7C, 32'h0, `DSM_SLVERR);
      wr(8'h7C, 32'h1, `DSM_SLVERR);
   endtask
   task automatic t_stream();
      wr(`DSM_A_RATE, 32'h9, `DSM_OKAY);
      trig(8'h87, 1'h0, 16'h1);
      chk(last, 32'hA5A50F0F);
      trig(8'h97, 1'h0, 16'h1);
      trig(8'hA7, 1'h0, 16'h2);
      trig(8'hA1, 1'h0, 16'h2);
      trig(8'hA2, 1'h0, 16'h2);
      trig(8'hB7, 1'h0, 16'h5);
      trig(8'hC7, 1'h1, 16'h5);
      trig(8'h80, 1'h0, 16'hA);
      trig(8'h37, 1'h0, 16'h0);
      trig(8'h84, 1'h0, 16'h0);
   endtask
   // Q15 shift rounds down: 1000 gives 999, -1000 gives -1000
   task automatic t_mix();
      wr(`DSM_A_AEN, 32'h1, `DSM_OKAY);
      wr(8'h20, 32'h3E8, `DSM_OKAY);
      wr(`DSM_A_OCTL, 32'h1, `DSM_OKAY);
      mchk(16'h03E7, 1'h0);
      chk(led_on, 32'h1);
      wr(`DSM_A_OFS1, 32'h3E8, `DSM_OKAY);
      mchk(16'h05DC, 1'h1);
      wr(`DSM_A_OCTL, 32'h3, `DSM_OKAY);
      mchk(16'h07CF, 1'h0);
      wr(`DSM_A_OCTL, 32'h5, `DSM_OKAY);
      mchk(16'h07CF, 1'h0);
      wr(`DSM_A_OCTL, 32'h2B, `DSM_OKAY);
      wr(`DSM_A_OFS1, 32'h1B58, `DSM_OKAY);
      mchk(16'h1D4C, 1'h1);
      rd(`DSM_A_STAT, 32'h15, `DSM_OKAY);
      wgp <= 1'h1;
      rd(`DSM_A_STAT, 32'h55, `DSM_OKAY);
      wr(`DSM_A_STAT, 32'hC, `DSM_OKAY);
      rd(`DSM_A_STAT, 32'h55, `DSM_OKAY);
      wr(`DSM_A_OFS1, 32'h0, `DSM_OKAY);
      wr(8'h20, 32'hFC18, `DSM_OKAY);
      mchk(16'hFC18, 1'h0);
      wr(`DSM_A_STAT, 32'hC, `DSM_OKAY);
      rd(`DSM_A_STAT, 32'h50, `DSM_OKAY);
      wr(`DSM_A_AEN, 32'h0, `DSM_OKAY);
      mchk(16'h0000, 1'h0);
      wr(`DSM_A_AEN, 32'h1, `DSM_OKAY);
      wr(`DSM_A_OCTL, 32'h0, `DSM_OKAY);
      mchk(16'h0000, 1'h0);
      chk(led_on, 32'h0);
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge clk_sys);
      rstn <= 1'h1;
      repeat (4) @(posedge clk_sys);
      t_regs();
      t_stream();
      t_mix();
      end_sim();
   end
   // Watchdog well beyond the roughly 1250 cycles needed
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      end_sim();
   end
endmodule // dsm_top_test
`default_nettype wire
